// File: src/fid_dev.sv
// flash device end: wake-up and identification command interpreter
// What this block does
// - bare wake opcode leaves power-down, waits delay
// - host keeps select high during wake delay
// - wake opcode, three dummies, then device byte
// - device byte repeats until select rises
// - identifier wake needs second delay before commands
// - wake opcode ignored while busy
// - zero address, then manufacturer and device bytes
// - manufacturer and device bytes alternate continuously
// - dual form: two bits per clock
// - host sends mode byte all ones
// - quad form: four bits per clock
// - four dummy bytes, then 64-bit unique number
// - manufacturer, memory type, capacity bytes
// - parameter table after address and eight dummies
// - table address upper bits zero, low byte start
// - power-down accepts only the wake opcode
`timescale 1ns/1ps
`default_nettype none
module fid_dev #(
  parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] MEMORY_TYPE = 8'h61, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h14, // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  fid_link_if.dev link,
  input wire logic busy,
  input wire logic pd_enter,
  output logic powered_down,
  output logic recovering
);
  import fid_pkg::*;

  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_OPCODE = 5'b00010,
    DS_INPUT = 5'b00100,
    DS_OUTPUT = 5'b01000,
    DS_IGNORE = 5'b10000
  } fid_dstate_type;

  // ****************************************
  // byte source
  // ****************************************
  // table header carries the discovery signature, the rest reads erased
  function automatic logic [7:0] param_table_f(input logic [7:0] a);
    case (a)
      8'h00: param_table_f = 8'h53;
      8'h01: param_table_f = 8'h46;
      8'h02: param_table_f = 8'h44;
      8'h03: param_table_f = 8'h50;
      default: param_table_f = 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] out_byte_f(input logic [7:0] opc, input logic [7:0] idx,
                                             input logic [7:0] start);
    case (opc)
      OPC_WAKE_ID: out_byte_f = DEVICE_ID;
      OPC_MFR_DEV, OPC_MFR_DEV_DUAL, OPC_MFR_DEV_QUAD:
        out_byte_f = idx[0] ? DEVICE_ID : MFR_ID;
      OPC_UNIQUE_ID: out_byte_f = UNIQUE_ID[{~idx[2:0], 3'b000} +: 8];
      OPC_IDENT: begin
        case (idx)
          8'h00: out_byte_f = MFR_ID;
          8'h01: out_byte_f = MEMORY_TYPE;
          default: out_byte_f = CAPACITY;
        endcase
      end
      OPC_PARAM_TABLE: out_byte_f = param_table_f(start + idx);
      default: out_byte_f = 8'hFF;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  fid_dstate_type state_ff, nxt_state;
  logic sclk_d_ff, nxt_sclk_d;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] opc_ff, nxt_opc;
  logic [23:0] addr_ff, nxt_addr;
  logic [2:0] lanes_ff, nxt_lanes;
  logic [7:0] lat_ff, nxt_lat;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] left_ff, nxt_left;
  logic [7:0] idx_ff, nxt_idx;
  logic [3:0] dout_ff, nxt_dout;
  logic [3:0] doe_ff, nxt_doe;
  logic pd_ff, nxt_pd;
  logic [WAKE_CNT_W-1:0] wake_cnt_ff, nxt_wake_cnt;

  logic rise;
  logic fall;
  logic sel;
  logic [7:0] opc_full;

  assign rise = link.sclk & ~sclk_d_ff;
  assign fall = ~link.sclk & sclk_d_ff;
  assign sel = ~link.cs_b;
  assign opc_full = {opc_ff[6:0], link.io[0]};

  always_comb begin
    nxt_state = state_ff;
    nxt_sclk_d = link.sclk;
    nxt_cnt = cnt_ff;
    nxt_opc = opc_ff;
    nxt_addr = addr_ff;
    nxt_lanes = lanes_ff;
    nxt_lat = lat_ff;
    nxt_sh = sh_ff;
    nxt_left = left_ff;
    nxt_idx = idx_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_pd = pd_ff;
    nxt_wake_cnt = wake_cnt_ff;
    if (wake_cnt_ff != '0) begin
      nxt_wake_cnt = wake_cnt_ff - 1'b1;
    end
    if (!sel) begin
      // select high ends any instruction and releases the lines
      if (state_ff != DS_IDLE) begin
        if (state_ff != DS_IGNORE && opc_ff == OPC_WAKE_ID && pd_ff && cnt_ff >= OPC_BITS) begin
          nxt_pd = 1'b0;
          if (cnt_ff == OPC_BITS) begin
            nxt_wake_cnt = WAKE_CNT_W'(WAKE_DELAY_CYC);
          end else begin
            nxt_wake_cnt = WAKE_CNT_W'(WAKE_WITH_ID_DELAY_CYC);
          end
        end
      end
      nxt_state = DS_IDLE;
      nxt_cnt = '0;
      nxt_doe = '0;
    end else begin
      if (rise && cnt_ff != CNT_MAX) begin
        nxt_cnt = cnt_ff + 8'h01;
      end
      case (state_ff)
        DS_IDLE: begin
          // no instruction is taken while a wake delay runs
          nxt_state = (wake_cnt_ff != '0) ? DS_IGNORE : DS_OPCODE;
          nxt_opc = '0;
        end
        DS_OPCODE: begin
          if (rise) begin
            nxt_opc = opc_full;
            if (cnt_ff == OPC_BITS - 8'h01) begin
              nxt_lat = fid_lat_f(opc_full);
              nxt_lanes = fid_lanes_f(opc_full);
              nxt_idx = 8'h01;
              nxt_left = BYTE_BITS;
              nxt_sh = out_byte_f(opc_full, 8'h00, 8'h00);
              if (pd_ff && opc_full != OPC_WAKE_ID) begin
                nxt_state = DS_IGNORE;
              end else if (opc_full == OPC_WAKE_ID && busy) begin
                nxt_state = DS_IGNORE;
              end else if (!fid_known_f(opc_full)) begin
                nxt_state = DS_IGNORE;
              end else if (fid_lat_f(opc_full) == LAT_NONE) begin
                nxt_state = DS_OUTPUT;
              end else begin
                nxt_state = DS_INPUT;
              end
            end
          end
        end
        DS_INPUT: begin
          if (rise) begin
            case (lanes_ff)
              LANES_4: nxt_addr = {addr_ff[19:0], link.io};
              LANES_2: nxt_addr = {addr_ff[21:0], link.io[1:0]};
              default: nxt_addr = {addr_ff[22:0], link.io[0]};
            endcase
            nxt_lat = lat_ff - 8'h01;
            if (lat_ff == 8'h01) begin
              nxt_state = DS_OUTPUT;
              nxt_sh = out_byte_f(opc_ff, 8'h00, nxt_addr[PARAM_START_LSB +: 8]);
            end
          end
        end
        DS_OUTPUT: begin
          if (fall) begin
            case (lanes_ff)
              LANES_4: begin
                nxt_dout = sh_ff[7:4];
                nxt_doe = 4'hF;
              end
              LANES_2: begin
                nxt_dout = {2'b00, sh_ff[7:6]};
                nxt_doe = 4'h3;
              end
              default: begin
                nxt_dout = {2'b00, sh_ff[7], 1'b0};
                nxt_doe = 4'h2;
              end
            endcase
            if (left_ff == {1'b0, lanes_ff}) begin
              nxt_sh = out_byte_f(opc_ff, idx_ff, addr_ff[PARAM_START_LSB +: 8]);
              nxt_left = BYTE_BITS;
              // identification wraps after capacity; table address wraps at its end
              if (opc_ff == OPC_IDENT && idx_ff == IDENT_LAST_IDX) begin
                nxt_idx = 8'h00;
              end else begin
                nxt_idx = idx_ff + 8'h01;
              end
            end else begin
              nxt_sh = sh_ff << lanes_ff;
              nxt_left = left_ff - {1'b0, lanes_ff};
            end
          end
        end
        DS_IGNORE: begin
          nxt_doe = '0;
        end
        default: nxt_state = DS_IDLE;
      endcase
    end
    // entry from the rest of the device wins over a release in the same cycle
    if (pd_enter) begin
      nxt_pd = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= DS_IDLE;
      sclk_d_ff <= 1'b0;
      cnt_ff <= '0;
      opc_ff <= '0;
      addr_ff <= '0;
      lanes_ff <= LANES_1;
      lat_ff <= '0;
      sh_ff <= '0;
      left_ff <= '0;
      idx_ff <= '0;
      dout_ff <= '0;
      doe_ff <= '0;
      pd_ff <= 1'b0;
      wake_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      sclk_d_ff <= nxt_sclk_d;
      cnt_ff <= nxt_cnt;
      opc_ff <= nxt_opc;
      addr_ff <= nxt_addr;
      lanes_ff <= nxt_lanes;
      lat_ff <= nxt_lat;
      sh_ff <= nxt_sh;
      left_ff <= nxt_left;
      idx_ff <= nxt_idx;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      pd_ff <= nxt_pd;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  assign link.dev_io_out = dout_ff;
  assign link.dev_io_oe = doe_ff;
  assign powered_down = pd_ff;
  assign recovering = (wake_cnt_ff != '0);

endmodule // fid_dev
`default_nettype wire

// File: src/fid_pkg.sv
// shared constants for the identification command link
package fid_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int WAKE_DELAY_NS = 3000;
  localparam int WAKE_WITH_ID_DELAY_NS = 1800;
  // least times, rounded up to whole clocks
  localparam int WAKE_DELAY_CYC = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_WITH_ID_DELAY_CYC = (WAKE_WITH_ID_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CNT_W = 9;
  // serial clock half period in system clocks; 4 leaves room for the device's edge detect
  localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
  localparam logic [8:0] CS_GAP_CYC = 9'h008;

  // ****************************************
  // opcodes and frame layout
  // ****************************************
  localparam logic [7:0] OPC_WAKE_ID = 8'hAB;
  localparam logic [7:0] OPC_MFR_DEV = 8'h90;
  localparam logic [7:0] OPC_MFR_DEV_DUAL = 8'h92;
  localparam logic [7:0] OPC_MFR_DEV_QUAD = 8'h94;
  localparam logic [7:0] OPC_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OPC_IDENT = 8'h9F;
  localparam logic [7:0] OPC_PARAM_TABLE = 8'h5A;
  localparam logic [7:0] OPC_BITS = 8'h08;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CONT_READ_MODE_BYTE = 8'hFF;
  // input clocks after the opcode: address, mode and dummy
  localparam logic [7:0] LAT_NONE = 8'h00;
  localparam logic [7:0] LAT_SINGLE_ADDR = 8'h18;
  localparam logic [7:0] LAT_DUAL_ADDR_MODE = 8'h10;
  localparam logic [7:0] LAT_QUAD_ADDR_MODE_DUMMY = 8'h0C;
  localparam logic [7:0] LAT_ADDR_DUMMY = 8'h20;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // start byte of the parameter table sits here once the dummy byte has shifted in
  localparam int PARAM_START_LSB = 8;
  localparam logic [7:0] IDENT_LAST_IDX = 8'h02;

  function automatic logic [7:0] fid_lat_f(input logic [7:0] opc);
    case (opc)
      OPC_WAKE_ID, OPC_MFR_DEV: fid_lat_f = LAT_SINGLE_ADDR;
      OPC_MFR_DEV_DUAL: fid_lat_f = LAT_DUAL_ADDR_MODE;
      OPC_MFR_DEV_QUAD: fid_lat_f = LAT_QUAD_ADDR_MODE_DUMMY;
      OPC_UNIQUE_ID, OPC_PARAM_TABLE: fid_lat_f = LAT_ADDR_DUMMY;
      default: fid_lat_f = LAT_NONE;
    endcase
  endfunction

  function automatic logic [2:0] fid_lanes_f(input logic [7:0] opc);
    case (opc)
      OPC_MFR_DEV_DUAL: fid_lanes_f = LANES_2;
      OPC_MFR_DEV_QUAD: fid_lanes_f = LANES_4;
      default: fid_lanes_f = LANES_1;
    endcase
  endfunction

  function automatic logic fid_known_f(input logic [7:0] opc);
    case (opc)
      OPC_WAKE_ID, OPC_MFR_DEV, OPC_MFR_DEV_DUAL, OPC_MFR_DEV_QUAD, OPC_UNIQUE_ID,
      OPC_IDENT, OPC_PARAM_TABLE: fid_known_f = 1'b1;
      default: fid_known_f = 1'b0;
    endcase
  endfunction

endpackage

// File: src/fid_link_if.sv
// serial link between the identification host and the flash device
`timescale 1ns/1ps
`default_nettype none
interface fid_link_if;
  logic cs_b;
  logic sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // wire level per line; an undriven line floats high as if pulled up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_io_oe[i]) begin
        io[i] = dev_io_out[i];
      end else if (host_io_oe[i]) begin
        io[i] = host_io_out[i];
      end else begin
        io[i] = 1'b1;
      end
    end
  end

  modport host (output cs_b, output sclk, output host_io_out, output host_io_oe, input io);
  modport dev (input cs_b, input sclk, input io, output dev_io_out, output dev_io_oe);
endinterface
`default_nettype wire

// File: src/fid_host.sv
// host end: issues one identification instruction per request
`timescale 1ns/1ps
`default_nettype none
module fid_host (
  input wire logic clk,
  input wire logic rst_b,
  fid_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_opcode,
  input wire logic [23:0] req_addr,
  input wire logic [8:0] req_len,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic done
);
  import fid_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RUN = 3'b010,
    HS_GAP = 3'b100
  } fid_hstate_type;

  fid_hstate_type state_ff, nxt_state;
  logic [2:0] half_ff, nxt_half;
  logic sclk_ff, nxt_sclk;
  logic cs_b_ff, nxt_cs_b;
  logic [11:0] k_ff, nxt_k;
  logic [11:0] total_ff, nxt_total;
  logic [7:0] opc_ff, nxt_opc;
  logic [31:0] tx_ff, nxt_tx;
  logic [7:0] lat_ff, nxt_lat;
  logic [2:0] lanes_ff, nxt_lanes;
  logic [3:0] io_out_ff, nxt_io_out;
  logic [3:0] io_oe_ff, nxt_io_oe;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0] rx_bits_ff, nxt_rx_bits;
  logic [8:0] gap_ff, nxt_gap;
  logic [8:0] len_ff, nxt_len;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic rx_valid_ff, nxt_rx_valid;
  logic done_ff, nxt_done;

  logic [23:0] addr_safe;
  logic [7:0] lat_new;
  logic [2:0] lanes_new;
  logic [11:0] clk_bytes;

  always_comb begin
    lanes_new = fid_lanes_f(req_opcode);
    // a bare wake carries no dummy bytes
    lat_new = (req_opcode == OPC_WAKE_ID && req_len == '0) ? LAT_NONE : fid_lat_f(req_opcode);
    case (req_opcode)
      OPC_MFR_DEV, OPC_MFR_DEV_DUAL, OPC_MFR_DEV_QUAD: addr_safe = '0;
      OPC_PARAM_TABLE: addr_safe = {16'h0000, req_addr[7:0]};
      default: addr_safe = req_addr;
    endcase
    case (lanes_new)
      LANES_4: clk_bytes = {2'b00, req_len, 1'b0};
      LANES_2: clk_bytes = {1'b0, req_len, 2'b00};
      default: clk_bytes = {req_len, 3'b000};
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_half = half_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_b = cs_b_ff;
    nxt_k = k_ff;
    nxt_total = total_ff;
    nxt_opc = opc_ff;
    nxt_tx = tx_ff;
    nxt_lat = lat_ff;
    nxt_lanes = lanes_ff;
    nxt_io_out = io_out_ff;
    nxt_io_oe = io_oe_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_gap = gap_ff;
    nxt_len = len_ff;
    nxt_rx_data = rx_data_ff;
    nxt_rx_valid = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      HS_IDLE: begin
        if (req_valid) begin
          nxt_state = HS_RUN;
          nxt_cs_b = 1'b0;
          nxt_half = '0;
          nxt_k = '0;
          nxt_len = req_len;
          nxt_lat = lat_new;
          nxt_lanes = lanes_new;
          nxt_total = {4'h0, OPC_BITS} + {4'h0, lat_new} + clk_bytes;
          // rotate rather than shift so the opcode is whole again at the end of the frame
          nxt_opc = {req_opcode[6:0], req_opcode[7]};
          nxt_io_out = {3'b000, req_opcode[7]};
          nxt_io_oe = 4'h1;
          nxt_tx = {addr_safe, CONT_READ_MODE_BYTE};
          nxt_rx_bits = '0;
        end
      end
      HS_RUN: begin
        nxt_half = half_ff + 3'h1;
        if (half_ff == SCLK_HALF_CYC - 3'h1) begin
          nxt_half = '0;
          nxt_sclk = ~sclk_ff;
          if (!sclk_ff) begin
            // rising edge: the device drove its bits on the previous fall
            nxt_k = k_ff + 12'h001;
            if (k_ff >= {4'h0, OPC_BITS} + {4'h0, lat_ff}) begin
              case (lanes_ff)
                LANES_4: nxt_rx_sh = {rx_sh_ff[3:0], link.io};
                LANES_2: nxt_rx_sh = {rx_sh_ff[5:0], link.io[1:0]};
                default: nxt_rx_sh = {rx_sh_ff[6:0], link.io[1]};
              endcase
              nxt_rx_bits = rx_bits_ff + {1'b0, lanes_ff};
              if (rx_bits_ff + {1'b0, lanes_ff} == BYTE_BITS) begin
                nxt_rx_bits = '0;
                nxt_rx_data = nxt_rx_sh;
                nxt_rx_valid = 1'b1;
              end
            end
          end else if (k_ff == total_ff) begin
            nxt_state = HS_GAP;
            nxt_cs_b = 1'b1;
            nxt_io_oe = '0;
            nxt_done = 1'b1;
            nxt_gap = CS_GAP_CYC;
            if (opc_ff == OPC_WAKE_ID) begin
              nxt_gap = (len_ff == '0) ? 9'(WAKE_DELAY_CYC) + CS_GAP_CYC
                                       : 9'(WAKE_WITH_ID_DELAY_CYC) + CS_GAP_CYC;
            end
          end else if (k_ff < {4'h0, OPC_BITS}) begin
            nxt_io_out = {3'b000, opc_ff[7]};
            nxt_opc = {opc_ff[6:0], opc_ff[7]};
          end else if (k_ff < {4'h0, OPC_BITS} + {4'h0, lat_ff}) begin
            case (lanes_ff)
              LANES_4: begin
                nxt_io_out = tx_ff[31:28];
                nxt_io_oe = 4'hF;
              end
              LANES_2: begin
                nxt_io_out = {2'b00, tx_ff[31:30]};
                nxt_io_oe = 4'h3;
              end
              default: begin
                nxt_io_out = {3'b000, tx_ff[31]};
                nxt_io_oe = 4'h1;
              end
            endcase
            nxt_tx = tx_ff << lanes_ff;
          end else begin
            nxt_io_oe = '0;
          end
        end
      end
      HS_GAP: begin
        nxt_gap = gap_ff - 9'h001;
        if (gap_ff == 9'h001) begin
          nxt_state = HS_IDLE;
        end
      end
      default: nxt_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= HS_IDLE;
      half_ff <= '0;
      sclk_ff <= 1'b0;
      cs_b_ff <= 1'b1;
      k_ff <= '0;
      total_ff <= '0;
      opc_ff <= '0;
      tx_ff <= '0;
      lat_ff <= '0;
      lanes_ff <= LANES_1;
      io_out_ff <= '0;
      io_oe_ff <= '0;
      rx_sh_ff <= '0;
      rx_bits_ff <= '0;
      gap_ff <= '0;
      len_ff <= '0;
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      half_ff <= nxt_half;
      sclk_ff <= nxt_sclk;
      cs_b_ff <= nxt_cs_b;
      k_ff <= nxt_k;
      total_ff <= nxt_total;
      opc_ff <= nxt_opc;
      tx_ff <= nxt_tx;
      lat_ff <= nxt_lat;
      lanes_ff <= nxt_lanes;
      io_out_ff <= nxt_io_out;
      io_oe_ff <= nxt_io_oe;
      rx_sh_ff <= nxt_rx_sh;
      rx_bits_ff <= nxt_rx_bits;
      gap_ff <= nxt_gap;
      len_ff <= nxt_len;
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      done_ff <= nxt_done;
    end
  end

  assign req_ready = (state_ff == HS_IDLE);
  assign link.cs_b = cs_b_ff;
  assign link.sclk = sclk_ff;
  assign link.host_io_out = io_out_ff;
  assign link.host_io_oe = io_oe_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign done = done_ff;

endmodule // fid_host
`default_nettype wire

// File: tb/fid_link_properties.sv
// concurrent checks on the identification link between host and device
`timescale 1ns/1ps
`default_nettype none
module fid_link_properties
  import fid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io,
  input wire logic powered_down,
  input wire logic recovering
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // helper: length of the current recovery
  // ****************************************
  logic [9:0] rec_cnt_ff;
  logic [9:0] nxt_rec_cnt;
  always_comb begin
    nxt_rec_cnt = recovering ? rec_cnt_ff + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_cnt_ff <= 10'h000;
    end else begin
      rec_cnt_ff <= nxt_rec_cnt;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  property p_oe_drop;
    cs_b [*3] |-> dev_io_oe == 4'h0;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("device drives outside a frame");
  property p_no_fight;
    (dev_io_oe & host_io_oe) == 4'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive one line");
  property p_oe_shape;
    dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_shape: assert property (p_oe_shape) else $error("device lane set is illegal");
  property p_out_on_fall;
    !cs_b && dev_io_oe != 4'h0 && $changed(dev_io_out) |-> !sclk;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved with sclk high");
  property p_sclk_idle;
    cs_b && $past(cs_b) |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not idle low");
  property p_half_period;
    $changed(sclk) |=> $stable(sclk) [*3];
  endproperty
  a_half_period: assert property (p_half_period) else $error("sclk half period short");
  property p_quiet_wake;
    recovering |-> cs_b;
  endproperty
  a_quiet_wake: assert property (p_quiet_wake) else $error("select low while waking");
  property p_wake_len;
    $fell(recovering) |-> rec_cnt_ff == WAKE_DELAY_CYC || rec_cnt_ff == WAKE_WITH_ID_DELAY_CYC;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake delay length wrong");

  c_quad: cover property (dev_io_oe == 4'hF);
  c_dual: cover property (dev_io_oe == 4'h3);
  c_wake: cover property ($fell(powered_down));
endmodule // fid_link_properties
`default_nettype wire

// File: tb/tb_flash_identification_commands.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_flash_identification_commands;
  import fid_pkg::*;
  // identity values below are arbitrary
  localparam logic [7:0] MFR = 8'h5D;
  localparam logic [7:0] DEV = 8'h27;
  localparam logic [7:0] MTYPE = 8'h4E;
  localparam logic [7:0] CAP = 8'h13;
  localparam logic [63:0] UID = 64'h1F2E_3D4C_5B6A_7988;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic busy = 1'b0;
  logic pd_enter = 1'b0;
  logic [7:0] req_opcode = 8'h00;
  logic [23:0] req_addr = 24'h00_0000;
  logic [8:0] req_len = 9'h000;
  logic req_ready, rx_valid, done, powered_down, recovering;
  logic [7:0] rx_data;
  logic [31:0] r;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h52cc_da30;

  fid_link_if link();
  fid_host fid_host_inst(.clk(clk), .rst_b(rst_b), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_opcode(req_opcode), .req_addr(req_addr), .req_len(req_len),
    .rx_data(rx_data), .rx_valid(rx_valid), .done(done));
  fid_dev #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEMORY_TYPE(MTYPE), .CAPACITY(CAP), .UNIQUE_ID(UID))
    fid_dev_inst(.clk(clk), .rst_b(rst_b), .link(link), .busy(busy), .pd_enter(pd_enter),
    .powered_down(powered_down), .recovering(recovering));
  fid_link_properties fid_link_properties_inst(.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b),
    .sclk(link.sclk), .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
    .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe), .io(link.io),
    .powered_down(powered_down), .recovering(recovering));

  always #4 clk = ~clk;

  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // ****************************************
  // reference model of the returned bytes
  // ****************************************
  function automatic logic [7:0] model(input logic [7:0] op, input int i, input logic [7:0] st);
    logic [7:0] k;
    k = st + i[7:0];
    case (op)
      OPC_WAKE_ID: model = DEV;
      OPC_IDENT: model = (i % 3 == 0) ? MFR : (i % 3 == 1) ? MTYPE : CAP;
      OPC_UNIQUE_ID: model = UID[8 * (7 - i % 8) +: 8];
      OPC_PARAM_TABLE: model = (k == 0) ? 8'h53 : (k == 1) ? 8'h46 : (k == 2) ? 8'h44 :
        (k == 3) ? 8'h50 : 8'hFF;
      default: model = (i % 2 == 0) ? MFR : DEV;
    endcase
  endfunction

  // an ignored frame leaves the lines floating high, so every byte reads all ones
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int len, input bit ign);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    req_opcode = op;
    req_addr = a;
    req_len = len[8:0];
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (rx_valid === 1'b1) begin
        chk(rx_data, ign ? 8'hFF : model(op, n, a[7:0]), "byte");
        n++;
      end
      if (done === 1'b1) break;
    end
    chk(n, len, "byte count");
  endtask

  task automatic wait_wake(input int exp);
    int c;
    int b;
    c = 0;
    b = 0;
    repeat (600) begin
      @(posedge clk);
      #1;
      if (recovering === 1'b1) c++;
      if (recovering === 1'b1 && req_ready !== 1'b0) b++;
    end
    chk(c, exp, "wake length");
    chk(b, 0, "host ready while waking");
    chk(powered_down, 1'b0, "still down");
  endtask

  task automatic pd_pulse;
    @(posedge clk);
    #1;
    pd_enter = 1'b1;
    @(posedge clk);
    #1;
    pd_enter = 1'b0;
    chk(powered_down, 1'b1, "power-down entry");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    run(OPC_IDENT, 24'h00_0000, 4, 1'b0);
    r = $random(seed);
    run(OPC_MFR_DEV, r[23:0], 3, 1'b0);
    r = $random(seed);
    run(OPC_MFR_DEV_DUAL, r[23:0], 3, 1'b0);
    r = $random(seed);
    run(OPC_MFR_DEV_QUAD, r[23:0], 4, 1'b0);
    run(OPC_UNIQUE_ID, 24'h00_0000, 9, 1'b0);
    for (int j = 0; j < 3; j++) begin
      r = $random(seed);
      run(OPC_PARAM_TABLE, {r[23:8], j == 0 ? 8'hFE : j == 1 ? 8'h00 : r[7:0]}, 5, 1'b0);
    end
    run(OPC_WAKE_ID, r[23:0], 2, 1'b0);
    busy = 1'b1;
    run(OPC_WAKE_ID, 24'h00_0000, 1, 1'b1);
    run(OPC_IDENT, 24'h00_0000, 3, 1'b0);
    busy = 1'b0;
    pd_pulse;
    run(OPC_IDENT, 24'h00_0000, 2, 1'b1);
    run(OPC_WAKE_ID, 24'h00_0000, 0, 1'b0);
    wait_wake(WAKE_DELAY_CYC);
    pd_pulse;
    run(OPC_WAKE_ID, 24'h00_0000, 2, 1'b0);
    wait_wake(WAKE_WITH_ID_DELAY_CYC);
    run(OPC_MFR_DEV, 24'h00_0000, 2, 1'b0);
    end_sim;
  end
endmodule // tb_flash_identification_commands
`default_nettype wire
